// ---- logic/plsr_defines.svh ----
`ifndef PLSR_DEFINES_SVH
`define PLSR_DEFINES_SVH

// Register indices; the APB byte address is four times the index
`define PLSR_P1_PARTNER_IDX 8'h18
`define PLSR_P1_LINK_IDX 8'h19
`define PLSR_P2_PARTNER_IDX 8'h28
`define PLSR_P2_LINK_IDX 8'h29
`define PLSR_P3_PARTNER_IDX 8'h38
`define PLSR_P3_LINK_IDX 8'h39
`define PLSR_P4_PARTNER_IDX 8'h48
`define PLSR_P4_LINK_IDX 8'h49
`define PLSR_RSVD_PARTNER_IDX 8'h58
`define PLSR_RSVD_LINK_IDX 8'h59

// Index split: high nibble is the port slot, low nibble the register
`define PLSR_FIRST_PORT 4'h1
`define PLSR_LAST_PORT 4'h4
`define PLSR_RSVD_PORT 4'h5
`define PLSR_PARTNER_NIB 4'h8
`define PLSR_LINK_NIB 4'h9

// Partner status fields
`define PLSR_FIBER_BIT 7
`define PLSR_PAUSE_HI 5
`define PLSR_PAUSE_LO 4
`define PLSR_P100FD_BIT 3
`define PLSR_P100HD_BIT 2
`define PLSR_P10FD_BIT 1
`define PLSR_P10HD_BIT 0

// Link status fields
`define PLSR_XOVER_BIT 7
`define PLSR_POLRVS_BIT 5
`define PLSR_TXFC_BIT 4
`define PLSR_RXFC_BIT 3
`define PLSR_SPEED_BIT 2
`define PLSR_DUPLEX_BIT 1

// Reset values
`define PLSR_FIBER_RESET 4'h3
`define PLSR_XOVER_RESET 4'hf
`define PLSR_STATUS_RESET 8'h00

`endif

// ---- logic/plsr_pkg.sv ----
package plsr_pkg;

   typedef enum logic [0:0] {
      plsr_st_idle = 1'b0,
      plsr_st_answer = 1'b1
   } plsr_state_type;

   typedef enum logic [1:0] {
      plsr_slot_none = 2'b00,
      plsr_slot_partner = 2'b01,
      plsr_slot_link = 2'b10,
      plsr_slot_rsvd = 2'b11
   } plsr_slot_type;

endpackage

// ---- logic/plsr_regs.sv ----
// Notes on behaviour
// - Partner status bit 7 is fixed fiber flag; ports 1,2 fiber, ports 3,4 copper.
// - Partner status bits 5-4 show the partner's pause ability, reset 00.
// - Partner status bit 3 shows partner 100 Mbps full-duplex ability.
// - Partner status bit 2 shows partner 100 Mbps half-duplex ability.
// - Partner status bit 1 shows partner 10 Mbps full-duplex ability.
// - Partner status bit 0 shows partner 10 Mbps half-duplex ability.
// - Link status bit 7 is writable crossover style select, reset 1.
// - Link status bit 5 shows receive polarity reversed.
// - Link status bit 4 shows transmit flow control active.
// - Link status bit 3 shows receive flow control active.
// - Link status bit 2 shows resolved speed, 1 for 100 Mbps.
// - Link status bit 1 shows resolved duplex, 1 for full.
// - Partner status sits at 0x18, 0x28, 0x38, 0x48; slot 0x58 reserved.
// - Link status sits at 0x19, 0x29, 0x39, 0x49; slot 0x59 reserved.
`timescale 1ns/10ps
`include "plsr_defines.svh"

module plsr_regs #(
   parameter int ADDR_W = 12,
   parameter logic [3:0] FIBER_PORTS = `PLSR_FIBER_RESET
) (
   input wire logic core_clk_in,
   input wire logic rst_n_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [ADDR_W-1:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   input wire logic [3:0] pstrb_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   input wire logic [7:0] partner_pause_in,
   input wire logic [3:0] partner_100fd_in,
   input wire logic [3:0] partner_100hd_in,
   input wire logic [3:0] partner_10fd_in,
   input wire logic [3:0] partner_10hd_in,
   input wire logic [3:0] polarity_reversed_in,
   input wire logic [3:0] tx_flow_active_in,
   input wire logic [3:0] rx_flow_active_in,
   input wire logic [3:0] speed_100_in,
   input wire logic [3:0] full_duplex_in,
   output logic [3:0] crossover_style_select_out
);

   plsr_pkg::plsr_state_type state_reg;
   plsr_pkg::plsr_state_type state_next;
   plsr_pkg::plsr_slot_type slot_w;

   logic [31:0] prdata_reg;
   logic [31:0] prdata_next;
   logic pready_reg;
   logic pslverr_reg;
   logic pslverr_next;
   logic [3:0] xover_reg;
   logic [3:0] xover_next;
   logic [3:0] fiber_reg;
   logic [7:0] pause_reg;
   logic [3:0] p100fd_reg;
   logic [3:0] p100hd_reg;
   logic [3:0] p10fd_reg;
   logic [3:0] p10hd_reg;
   logic [3:0] polrvs_reg;
   logic [3:0] txfc_reg;
   logic [3:0] rxfc_reg;
   logic [3:0] speed_reg;
   logic [3:0] duplex_reg;

   // Status inputs are registered once; reads see them one cycle late
   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         fiber_reg <= FIBER_PORTS;
         pause_reg <= `PLSR_STATUS_RESET;
         p100fd_reg <= 4'h0;
         p100hd_reg <= 4'h0;
         p10fd_reg <= 4'h0;
         p10hd_reg <= 4'h0;
         polrvs_reg <= 4'h0;
         txfc_reg <= 4'h0;
         rxfc_reg <= 4'h0;
         speed_reg <= 4'h0;
         duplex_reg <= 4'h0;
      end else begin
         fiber_reg <= FIBER_PORTS;
         pause_reg <= partner_pause_in;
         p100fd_reg <= partner_100fd_in;
         p100hd_reg <= partner_100hd_in;
         p10fd_reg <= partner_10fd_in;
         p10hd_reg <= partner_10hd_in;
         polrvs_reg <= polarity_reversed_in;
         txfc_reg <= tx_flow_active_in;
         rxfc_reg <= rx_flow_active_in;
         speed_reg <= speed_100_in;
         duplex_reg <= full_duplex_in;
      end
   end

   // Unlisted bits stay zero
   function automatic logic [7:0] partner_byte(input logic [1:0] p);
      logic [7:0] b;
      b = `PLSR_STATUS_RESET;
      b[`PLSR_FIBER_BIT] = fiber_reg[p];
      b[`PLSR_PAUSE_HI] = pause_reg[2*p+1];
      b[`PLSR_PAUSE_LO] = pause_reg[2*p];
      b[`PLSR_P100FD_BIT] = p100fd_reg[p];
      b[`PLSR_P100HD_BIT] = p100hd_reg[p];
      b[`PLSR_P10FD_BIT] = p10fd_reg[p];
      b[`PLSR_P10HD_BIT] = p10hd_reg[p];
      return b;
   endfunction

   function automatic logic [7:0] link_byte(input logic [1:0] p);
      logic [7:0] b;
      b = `PLSR_STATUS_RESET;
      b[`PLSR_XOVER_BIT] = xover_reg[p];
      b[`PLSR_POLRVS_BIT] = polrvs_reg[p];
      b[`PLSR_TXFC_BIT] = txfc_reg[p];
      b[`PLSR_RXFC_BIT] = rxfc_reg[p];
      b[`PLSR_SPEED_BIT] = speed_reg[p];
      b[`PLSR_DUPLEX_BIT] = duplex_reg[p];
      return b;
   endfunction

   // Address decode
   wire [7:0] idx_w = paddr_in[9:2];
   wire [3:0] port_nib_w = idx_w[7:4];
   wire [3:0] reg_nib_w = idx_w[3:0];
   wire legal_addr_w = (paddr_in[1:0] == 2'b00) && (paddr_in[ADDR_W-1:10] == '0);
   wire port_hit_w = (port_nib_w >= `PLSR_FIRST_PORT) && (port_nib_w <= `PLSR_LAST_PORT);
   wire rsvd_hit_w = (port_nib_w == `PLSR_RSVD_PORT);
   wire partner_nib_w = (reg_nib_w == `PLSR_PARTNER_NIB);
   wire link_nib_w = (reg_nib_w == `PLSR_LINK_NIB);
   wire [3:0] port_off_w = port_nib_w - `PLSR_FIRST_PORT;
   wire [1:0] port_sel_w = port_off_w[1:0];

   assign slot_w = (!legal_addr_w || !(partner_nib_w || link_nib_w)) ?
                   plsr_pkg::plsr_slot_none :
                   rsvd_hit_w ? plsr_pkg::plsr_slot_rsvd :
                   !port_hit_w ? plsr_pkg::plsr_slot_none :
                   partner_nib_w ? plsr_pkg::plsr_slot_partner :
                   plsr_pkg::plsr_slot_link;

   // A plain assign would not wake on status regs read inside the functions
   logic [7:0] rd_byte_w;
   always_comb begin
      if (slot_w == plsr_pkg::plsr_slot_partner) begin
         rd_byte_w = partner_byte(port_sel_w);
      end else if (slot_w == plsr_pkg::plsr_slot_link) begin
         rd_byte_w = link_byte(port_sel_w);
      end else begin
         rd_byte_w = `PLSR_STATUS_RESET;
      end
   end

   // One wait state: answer comes in the second access cycle
   wire access_w = psel_in && penable_in;
   wire start_w = access_w && (state_reg == plsr_pkg::plsr_st_idle);
   wire commit_w = access_w && (state_reg == plsr_pkg::plsr_st_answer);
   wire xover_wr_w = commit_w && pwrite_in && pstrb_in[0] &&
                     (slot_w == plsr_pkg::plsr_slot_link);

   assign state_next = start_w ? plsr_pkg::plsr_st_answer : plsr_pkg::plsr_st_idle;
   assign prdata_next = (start_w && !pwrite_in) ? {24'h0000_00, rd_byte_w} : 32'h0000_0000;
   assign pslverr_next = start_w && (slot_w == plsr_pkg::plsr_slot_none);

   // Only the crossover selector takes write data; all other bits ignore it
   always_comb begin
      xover_next = xover_reg;
      if (xover_wr_w) begin
         xover_next[port_sel_w] = pwdata_in[`PLSR_XOVER_BIT];
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         state_reg <= plsr_pkg::plsr_st_idle;
         pready_reg <= 1'b0;
         prdata_reg <= 32'h0000_0000;
         pslverr_reg <= 1'b0;
         xover_reg <= `PLSR_XOVER_RESET;
      end else begin
         state_reg <= state_next;
         pready_reg <= start_w;
         prdata_reg <= prdata_next;
         pslverr_reg <= pslverr_next;
         xover_reg <= xover_next;
      end
   end

   assign prdata_out = prdata_reg;
   assign pready_out = pready_reg;
   assign pslverr_out = pslverr_reg;
   assign crossover_style_select_out = xover_reg;

   // Checks

   property p_fiber_read;
      @(posedge core_clk_in) disable iff (!rst_n_in)
      (start_w && !pwrite_in && slot_w == plsr_pkg::plsr_slot_partner) |=>
         prdata_out[`PLSR_FIBER_BIT] == FIBER_PORTS[$past(port_sel_w)];
   endproperty
   a_fiber_read: assert property (p_fiber_read)
      else $error("fiber flag read back wrong");

   property p_fiber_fixed;
      @(posedge core_clk_in) disable iff (!rst_n_in)
      $rose(rst_n_in) ##1 1'b1 |-> fiber_reg == FIBER_PORTS;
   endproperty
   a_fiber_fixed: assert property (p_fiber_fixed)
      else $error("fiber flags differ from port media");

   property p_pause_read;
      @(posedge core_clk_in) disable iff (!rst_n_in)
      (start_w && !pwrite_in && slot_w == plsr_pkg::plsr_slot_partner &&
       port_sel_w == 2'b00) |=>
         prdata_out[`PLSR_PAUSE_HI:`PLSR_PAUSE_LO] == $past(pause_reg[1:0]);
   endproperty
   a_pause_read: assert property (p_pause_read)
      else $error("pause ability read back wrong");

   property p_ability_read;
      @(posedge core_clk_in) disable iff (!rst_n_in)
      (start_w && !pwrite_in && slot_w == plsr_pkg::plsr_slot_partner &&
       port_sel_w == 2'b11) |=>
         prdata_out[3:0] == {$past(p100fd_reg[3]), $past(p100hd_reg[3]),
                             $past(p10fd_reg[3]), $past(p10hd_reg[3])};
   endproperty
   a_ability_read: assert property (p_ability_read)
      else $error("partner speed abilities read back wrong");

   property p_xover_write;
      @(posedge core_clk_in) disable iff (!rst_n_in)
      xover_wr_w |=> pready_out == 1'b0 ##0
         crossover_style_select_out[$past(port_sel_w)] == $past(pwdata_in[`PLSR_XOVER_BIT]);
   endproperty
   a_xover_write: assert property (p_xover_write)
      else $error("crossover select write lost");

   property p_xover_hold;
      @(posedge core_clk_in) disable iff (!rst_n_in)
      !xover_wr_w |=> $stable(crossover_style_select_out);
   endproperty
   a_xover_hold: assert property (p_xover_hold)
      else $error("crossover select changed without write");

   property p_link_read;
      @(posedge core_clk_in) disable iff (!rst_n_in)
      (start_w && !pwrite_in && slot_w == plsr_pkg::plsr_slot_link &&
       port_sel_w == 2'b01) |=>
         prdata_out[5:0] == {$past(polrvs_reg[1]), $past(txfc_reg[1]), $past(rxfc_reg[1]),
                             $past(speed_reg[1]), $past(duplex_reg[1]), 1'b0};
   endproperty
   a_link_read: assert property (p_link_read)
      else $error("link status read back wrong");

   property p_map_answer;
      @(posedge core_clk_in) disable iff (!rst_n_in)
      start_w |=> pready_out && (pslverr_out == $past(slot_w == plsr_pkg::plsr_slot_none))
         ##1 !pready_out;
   endproperty
   a_map_answer: assert property (p_map_answer)
      else $error("answer timing or error flag wrong");

   property p_rsvd_zero;
      @(posedge core_clk_in) disable iff (!rst_n_in)
      (start_w && slot_w == plsr_pkg::plsr_slot_rsvd) |=>
         prdata_out == 32'h0000_0000 && !pslverr_out;
   endproperty
   a_rsvd_zero: assert property (p_rsvd_zero)
      else $error("reserved slot did not read zero");

   property p_upper_zero;
      @(posedge core_clk_in) disable iff (!rst_n_in)
      pready_out |-> prdata_out[31:8] == 24'h0000_00 && prdata_out[6] == 1'b0 &&
         (prdata_out[0] == 1'b0 || !$past(slot_w == plsr_pkg::plsr_slot_link));
   endproperty
   a_upper_zero: assert property (p_upper_zero)
      else $error("reserved bits read non-zero");

   property p_partner_reset;
      @(posedge core_clk_in)
      !rst_n_in |=> fiber_reg == FIBER_PORTS &&
         {pause_reg, p100fd_reg, p100hd_reg, p10fd_reg, p10hd_reg} == 24'h00_0000;
   endproperty
   a_partner_reset: assert property (p_partner_reset)
      else $error("partner status not cleared by reset");

   property p_link_reset;
      @(posedge core_clk_in)
      !rst_n_in |=> {polrvs_reg, txfc_reg, rxfc_reg, speed_reg, duplex_reg} == 20'h0_0000;
   endproperty
   a_link_reset: assert property (p_link_reset)
      else $error("link status not cleared by reset");

   property p_xover_reset;
      @(posedge core_clk_in)
      !rst_n_in |=> crossover_style_select_out == `PLSR_XOVER_RESET;
   endproperty
   a_xover_reset: assert property (p_xover_reset)
      else $error("crossover select not set by reset");

   property p_partner_follow;
      @(posedge core_clk_in) disable iff (!rst_n_in)
      1'b1 |=> {pause_reg, p100fd_reg, p100hd_reg, p10fd_reg, p10hd_reg} ==
         $past({partner_pause_in, partner_100fd_in, partner_100hd_in, partner_10fd_in,
                partner_10hd_in});
   endproperty
   a_partner_follow: assert property (p_partner_follow)
      else $error("partner status not tracking its inputs");

   property p_link_follow;
      @(posedge core_clk_in) disable iff (!rst_n_in)
      1'b1 |=> {polrvs_reg, txfc_reg, rxfc_reg, speed_reg, duplex_reg} ==
         $past({polarity_reversed_in, tx_flow_active_in, rx_flow_active_in, speed_100_in,
                full_duplex_in});
   endproperty
   a_link_follow: assert property (p_link_follow)
      else $error("link status not tracking its inputs");

   property p_pause_read_p4;
      @(posedge core_clk_in) disable iff (!rst_n_in)
      (start_w && !pwrite_in && slot_w == plsr_pkg::plsr_slot_partner &&
       port_sel_w == 2'b11) |=>
         prdata_out[`PLSR_PAUSE_HI:`PLSR_PAUSE_LO] == $past(pause_reg[7:6]);
   endproperty
   a_pause_read_p4: assert property (p_pause_read_p4)
      else $error("last port pause ability read back wrong");

   property p_ability_read_p1;
      @(posedge core_clk_in) disable iff (!rst_n_in)
      (start_w && !pwrite_in && slot_w == plsr_pkg::plsr_slot_partner &&
       port_sel_w == 2'b00) |=>
         prdata_out[3:0] == $past({p100fd_reg[0], p100hd_reg[0], p10fd_reg[0], p10hd_reg[0]});
   endproperty
   a_ability_read_p1: assert property (p_ability_read_p1)
      else $error("first port speed abilities read back wrong");

   property p_link_read_p3;
      @(posedge core_clk_in) disable iff (!rst_n_in)
      (start_w && !pwrite_in && slot_w == plsr_pkg::plsr_slot_link &&
       port_sel_w == 2'b10) |=>
         prdata_out[7:1] == $past({crossover_style_select_out[2], 1'b0, polrvs_reg[2],
                                   txfc_reg[2], rxfc_reg[2], speed_reg[2], duplex_reg[2]});
   endproperty
   a_link_read_p3: assert property (p_link_read_p3)
      else $error("third port link status read back wrong");

   property p_other_nowrite;
      @(posedge core_clk_in) disable iff (!rst_n_in)
      (commit_w && pwrite_in && slot_w != plsr_pkg::plsr_slot_link) |=>
         $stable(crossover_style_select_out);
   endproperty
   a_other_nowrite: assert property (p_other_nowrite)
      else $error("write outside link status moved the selector");

   property p_write_zero;
      @(posedge core_clk_in) disable iff (!rst_n_in)
      (start_w && pwrite_in) |=> prdata_out == 32'h0000_0000;
   endproperty
   a_write_zero: assert property (p_write_zero)
      else $error("read data not zero on a write");

   property p_quiet;
      @(posedge core_clk_in) disable iff (!rst_n_in)
      !start_w |=> !pready_out && !pslverr_out;
   endproperty
   a_quiet: assert property (p_quiet)
      else $error("answer without a request");

   property p_unmapped_err;
      @(posedge core_clk_in) disable iff (!rst_n_in)
      (start_w && !legal_addr_w) |=> pslverr_out && prdata_out == 32'h0000_0000;
   endproperty
   a_unmapped_err: assert property (p_unmapped_err)
      else $error("unmapped address not refused");

endmodule

// ---- testbench/plsr_link_partner.sv ----
`timescale 1ns/10ps
module plsr_link_partner (
   input wire logic core_clk_in,
   input wire logic rst_n_in,
   input wire logic change_in,
   output logic [7:0] pause_out,
   output logic [3:0] fd100_out,
   output logic [3:0] hd100_out,
   output logic [3:0] fd10_out,
   output logic [3:0] hd10_out,
   output logic [3:0] pol_out,
   output logic [3:0] txfc_out,
   output logic [3:0] rxfc_out,
   output logic [3:0] spd_out,
   output logic [3:0] dup_out
);
   // Link state only moves on request, so a read always sees a settled value
   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         {pause_out, fd100_out, hd100_out, fd10_out, hd10_out} <= 24'h00_0000;
         {pol_out, txfc_out, rxfc_out, spd_out, dup_out} <= 20'h0_0000;
      end else if (change_in) begin
         {pause_out, fd100_out, hd100_out, fd10_out, hd10_out} <= 24'($urandom);
         {pol_out, txfc_out, rxfc_out, spd_out, dup_out} <= 20'($urandom);
      end
   end
endmodule

// ---- testbench/plsr_regs_tb.sv ----
`timescale 1ns/10ps
module plsr_regs_tb;
   localparam logic [3:0] FIB = 4'b0011;
   logic core_clk_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic change = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [3:0] pstrb = 4'h0;
   logic [31:0] prdata, rd;
   logic pready, pslverr, er;
   logic [7:0] pause;
   logic [3:0] fd100, hd100, fd10, hd10, pol, txfc, rxfc, spd, dup, xsel;
   logic [3:0] xs_exp = 4'hf;
   int miscompares = 0;
   int samples_checked = 0;
   always #4 core_clk_in = ~core_clk_in;

   plsr_regs plsr_regs_i (
      .core_clk_in(core_clk_in),
      .rst_n_in(rst_n_in),
      .psel_in(psel),
      .penable_in(penable),
      .pwrite_in(pwrite),
      .paddr_in(paddr),
      .pwdata_in(pwdata),
      .pstrb_in(pstrb),
      .prdata_out(prdata),
      .pready_out(pready),
      .pslverr_out(pslverr),
      .partner_pause_in(pause),
      .partner_100fd_in(fd100),
      .partner_100hd_in(hd100),
      .partner_10fd_in(fd10),
      .partner_10hd_in(hd10),
      .polarity_reversed_in(pol),
      .tx_flow_active_in(txfc),
      .rx_flow_active_in(rxfc),
      .speed_100_in(spd),
      .full_duplex_in(dup),
      .crossover_style_select_out(xsel)
   );

   plsr_link_partner plsr_link_partner_i (
      .core_clk_in(core_clk_in),
      .rst_n_in(rst_n_in),
      .change_in(change),
      .pause_out(pause),
      .fd100_out(fd100),
      .hd100_out(hd100),
      .fd10_out(fd10),
      .hd10_out(hd10),
      .pol_out(pol),
      .txfc_out(txfc),
      .rxfc_out(rxfc),
      .spd_out(spd),
      .dup_out(dup)
   );

   function automatic logic [11:0] addr(input int p, input logic link);
      return 12'h060 + 12'h040 * 12'(p) + (link ? 12'h004 : 12'h000);
   endfunction

   function automatic logic [31:0] exp_partner(input int p);
      return {24'h00_0000, FIB[p], 1'b0, pause[2*p+:2], fd100[p], hd100[p], fd10[p], hd10[p]};
   endfunction

   function automatic logic [31:0] exp_link(input int p);
      return {24'h00_0000, xs_exp[p], 1'b0, pol[p], txfc[p], rxfc[p], spd[p], dup[p], 1'b0};
   endfunction

   task automatic conclude();
      $display("checks %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
         miscompares++;
      end
   endtask

   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                      input logic [3:0] st);
      int n;
      @(posedge core_clk_in);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      pstrb <= st;
      @(posedge core_clk_in);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge core_clk_in);
         n++;
      end while (pready !== 1'b1 && n < 16);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1) begin
         miscompares++;
         conclude();
      end
   endtask

   task automatic check_all();
      for (int p = 0; p < 4; p++) begin
         apb(1'b0, addr(p, 1'b0), 32'h0000_0000, 4'h0);
         chk(rd, exp_partner(p));
         chk({31'h0000_0000, er}, 32'h0000_0000);
         apb(1'b0, addr(p, 1'b1), 32'h0000_0000, 4'h0);
         chk(rd, exp_link(p));
         chk({31'h0000_0000, er}, 32'h0000_0000);
      end
      chk({28'h000_0000, xsel}, {28'h000_0000, xs_exp});
   endtask

   initial begin
      int p;
      logic [31:0] wd;
      logic [3:0] st;
      void'($urandom(32'h5f12_8293));
      repeat (2) @(posedge core_clk_in);
      rst_n_in <= 1'b1;
      check_all();
      for (int k = 0; k < 2; k++) begin
         apb(1'b0, addr(4, k[0]), 32'h0000_0000, 4'h0);
         chk(rd, 32'h0000_0000);
         chk({31'h0000_0000, er}, 32'h0000_0000);
      end
      $display("test reset values done");
      for (int i = 0; i < 24; i++) begin
         @(posedge core_clk_in);
         change <= 1'b1;
         @(posedge core_clk_in);
         change <= 1'b0;
         p = $urandom_range(3);
         wd = $urandom;
         st = 4'($urandom);
         apb(1'b1, addr(p, 1'b1), wd, st);
         if (st[0]) xs_exp[p] = wd[7];
         // Partner registers are read-only, so this write must leave them alone
         apb(1'b1, addr(p, 1'b0), $urandom, 4'hf);
         check_all();
      end
      $display("test random status done");
      // A second reset must restore the selectors that the random writes moved
      @(posedge core_clk_in);
      rst_n_in <= 1'b0;
      repeat (2) @(posedge core_clk_in);
      rst_n_in <= 1'b1;
      xs_exp = 4'hf;
      check_all();
      $display("test second reset done");
      apb(1'b1, addr(4, 1'b1), 32'h0000_0000, 4'hf);
      apb(1'b0, addr(4, 1'b1), 32'h0000_0000, 4'h0);
      chk(rd, 32'h0000_0000);
      apb(1'b0, 12'h460, 32'h0000_0000, 4'h0);
      chk({31'h0000_0000, er}, 32'h0000_0001);
      chk(rd, 32'h0000_0000);
      apb(1'b0, 12'h068, 32'h0000_0000, 4'h0);
      chk({31'h0000_0000, er}, 32'h0000_0001);
      chk(rd, 32'h0000_0000);
      apb(1'b1, 12'h061, ~{24'h00_0000, xs_exp[0], 7'h00}, 4'hf);
      chk({31'h0000_0000, er}, 32'h0000_0001);
      check_all();
      $display("test refusals done");
      conclude();
   end
endmodule
